// file: ezc_pkg.sv
// constants, register map and types of the endpoint zero control block
// assumes one 25 MHz clock shared with the serial interface engine and the mcu bus
// Operation
// - seven IN, seven OUT typed endpoints besides zero
// - control traffic only on endpoint zero
// - good setup stored, pending set, ACK, interrupt
// - pending flag forces NAK on ep0 stages
// - clearing setup interrupt clears pending flag
// - halt both halves for bad request: STALL
// - good OUT data: store, count, toggle, refuse, ACK
// - refuse bit set: NAK, no data moved
// - halt bit set: STALL handshake
// - OUT packet with errors: no handshake
// - IN packet: toggle, refuse, interrupt on ACK
// - no IN handshake: keep packet for retry
// - control write: setup, optional OUT, IN status
// - control read: setup, IN data, OUT status
// - OUT status zero-length DATA1 accepted and acknowledged
package ezc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int BUF_AW = 4;
  localparam int BUF_DEPTH = 16;
  localparam int NUM_EP = 7;
  localparam int TYPE_REGS = 4;
  // register offsets
  localparam logic [3:0] REG_OUT0_CFG = 4'h0;
  localparam logic [3:0] REG_OUT0_BASE = 4'h1;
  localparam logic [3:0] REG_OUT0_SIZE = 4'h2;
  localparam logic [3:0] REG_OUT0_COUNT = 4'h3;
  localparam logic [3:0] REG_IN0_CFG = 4'h4;
  localparam logic [3:0] REG_IN0_BASE = 4'h5;
  localparam logic [3:0] REG_IN0_SIZE = 4'h6;
  localparam logic [3:0] REG_IN0_COUNT = 4'h7;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_INT_FLAGS = 4'h9;
  localparam logic [3:0] REG_BUF_PTR = 4'ha;
  localparam logic [3:0] REG_BUF_DATA = 4'hb;
  localparam logic [3:0] REG_EP_TYPE0 = 4'hc;
  // configuration byte fields
  localparam int CFG_ENABLE = 7;
  localparam int CFG_INT_EN = 6;
  localparam int CFG_HALT = 5;
  localparam int CFG_TOGGLE = 4;
  localparam int CFG_REFUSE = 3;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // status and interrupt flag fields
  localparam int STATUS_PENDING = 0;
  localparam int INT_SETUP = 0;
  localparam int INT_OUT0 = 1;
  localparam int INT_IN0 = 2;
  // token and handshake codes on the engine side
  localparam logic [1:0] TOK_OUT = 2'h1;
  localparam logic [1:0] TOK_IN = 2'h2;
  localparam logic [1:0] TOK_SETUP = 2'h3;
  localparam logic [1:0] HS_ACK = 2'h0;
  localparam logic [1:0] HS_NAK = 2'h1;
  localparam logic [1:0] HS_STALL = 2'h2;
  localparam logic [1:0] HS_NONE = 2'h3;
  localparam logic [3:0] EP0 = 4'h0;
  localparam logic [3:0] SETUP_BASE = 4'h8;
  localparam logic [3:0] SETUP_LEN = 4'h8;
  localparam logic [3:0] MAX_PKT = 4'h8;
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_OUT, ST_TX, ST_WAIT} ezc_state_type;
endpackage

// file: ezc_buf_mem.sv
// small byte buffer with one write port and a registered read port
// assumes writes and reads come from logic on the same clock
`timescale 1ns/1ps
module ezc_buf_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4,
  parameter int DW = 8
)
(
  input wire logic i_clock,
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [DW-1:0] i_wr_data,
  input wire logic [AW-1:0] i_rd_addr,
  output logic [DW-1:0] o_rd_data
);
  logic [DW-1:0] mem [0:DEPTH-1];

  // write port
  always_ff @(posedge i_clock)
  begin
    if (i_wr_en)
    begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  // read data always from a register
  always_ff @(posedge i_clock)
  begin
    o_rd_data <= mem[i_rd_addr];
  end
endmodule

// file: ezc_ep0_ctrl.sv
// endpoint zero control transfer logic of the endpoint buffer unit
// assumes token, receive and transmit strobes come from the engine on i_clock
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module ezc_ep0_ctrl
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_tok_valid,
  input wire logic [1:0] i_tok_pid,
  input wire logic [3:0] i_tok_ep,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_end,
  input wire logic i_rx_ok,
  input wire logic i_rx_data1,
  input wire logic i_tx_ready,
  input wire logic i_hs_ack,
  input wire logic i_hs_timeout,
  output logic o_hs_valid,
  output logic [1:0] o_hs_code,
  output logic o_tx_start,
  output logic o_tx_data1,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic o_tx_end,
  output logic o_setup_irq,
  output logic o_ep0_out_irq,
  output logic o_ep0_in_irq,
  output logic [13:0] o_in_ep_type,
  output logic [13:0] o_out_ep_type
);
  ezc_pkg::ezc_state_type state;
  logic [7:0] out_cfg;
  logic [7:0] in_cfg;
  logic [7:0] next_out_cfg;
  logic [7:0] next_in_cfg;
  logic [3:0] out_base;
  logic [3:0] in_base;
  logic [3:0] out_size;
  logic [3:0] in_size;
  logic [3:0] out_count;
  logic [3:0] in_count;
  logic pending;
  logic [2:0] int_flags;
  logic [3:0] buf_ptr;
  logic [3:0] next_buf_ptr;
  logic [7:0] ep_type [0:3];
  logic [1:0] resp;
  logic [3:0] rx_cnt;
  logic [3:0] tx_idx;
  logic [7:0] out_rdata;
  logic tok0;
  logic rx_ok_end;
  logic ev_setup;
  logic ev_out;
  logic ev_in;
  logic tx_fire;
  logic out_we;
  logic [3:0] out_waddr;
  logic [3:0] in_raddr;
  logic buf_access;
  logic [1:0] out_decide;
  logic [1:0] in_decide;

  // answer for a data or status token, none if disabled, then pending, then halt, then refuse
  function automatic logic [1:0] decide_resp(input logic [7:0] cfg, input logic busy);
    logic [1:0] r;
    r = ezc_pkg::HS_ACK;
    if (!cfg[ezc_pkg::CFG_ENABLE])
      r = ezc_pkg::HS_NONE;
    else if (busy)
      r = ezc_pkg::HS_NAK;
    else if (cfg[ezc_pkg::CFG_HALT])
      r = ezc_pkg::HS_STALL;
    else if (cfg[ezc_pkg::CFG_REFUSE])
      r = ezc_pkg::HS_NAK;
    return r;
  endfunction

  // transaction events shared by the state machine and the registers
  always_comb
  begin
    tok0 = i_tok_valid && (i_tok_ep == ezc_pkg::EP0) && (state == ezc_pkg::ST_IDLE);
    rx_ok_end = i_rx_end && i_rx_ok;
    ev_setup = (state == ezc_pkg::ST_SETUP) && rx_ok_end && (rx_cnt == ezc_pkg::SETUP_LEN);
    ev_out = (state == ezc_pkg::ST_OUT) && rx_ok_end && (resp == ezc_pkg::HS_ACK)
      && (i_rx_data1 == out_cfg[ezc_pkg::CFG_TOGGLE]);
    ev_in = (state == ezc_pkg::ST_WAIT) && i_hs_ack;
    tx_fire = o_tx_valid && i_tx_ready;
    out_decide = decide_resp(out_cfg, pending);
    in_decide = decide_resp(in_cfg, pending);
    buf_access = (i_addr == ezc_pkg::REG_BUF_DATA) && (i_wr || i_rd);
  end

  // receive writes: setup bytes to their fixed slot, OUT data up to min(OUT size, 8) whenever the token's answer is ACK, even if the packet is then bad
  always_comb
  begin
    out_we = 1'b0;
    out_waddr = 4'(out_base + rx_cnt);
    if (i_rx_valid && (rx_cnt < ezc_pkg::MAX_PKT))
    begin
      if (state == ezc_pkg::ST_SETUP)
      begin
        out_we = 1'b1;
        out_waddr = 4'(ezc_pkg::SETUP_BASE + rx_cnt);
      end
      else if ((state == ezc_pkg::ST_OUT) && (resp == ezc_pkg::HS_ACK) && (rx_cnt < out_size))
      begin
        out_we = 1'b1;
      end
    end
    in_raddr = 4'(in_base + tx_idx + {3'h0, tx_fire});
    next_buf_ptr = (i_wr && (i_addr == ezc_pkg::REG_BUF_PTR)) ? i_wdata[3:0]
      : (buf_access ? 4'(buf_ptr + 4'h1) : buf_ptr);
  end

  // buffer written by the engine, read by the controller
  ezc_buf_mem #(.DEPTH(ezc_pkg::BUF_DEPTH), .AW(ezc_pkg::BUF_AW), .DW(ezc_pkg::DATA_W)) u_out_mem
  (
    .i_clock(i_clock),
    .i_wr_en(out_we),
    .i_wr_addr(out_waddr),
    .i_wr_data(i_rx_data),
    .i_rd_addr(next_buf_ptr),
    .o_rd_data(out_rdata)
  );

  // buffer written by the controller, read by the transmitter
  ezc_buf_mem #(.DEPTH(ezc_pkg::BUF_DEPTH), .AW(ezc_pkg::BUF_AW), .DW(ezc_pkg::DATA_W)) u_in_mem
  (
    .i_clock(i_clock),
    .i_wr_en(i_wr && (i_addr == ezc_pkg::REG_BUF_DATA)),
    .i_wr_addr(buf_ptr),
    .i_wr_data(i_wdata),
    .i_rd_addr(in_raddr),
    .o_rd_data(o_tx_data)
  );

  // transaction state machine for setup, data and status stages
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      state <= ezc_pkg::ST_IDLE;
      resp <= ezc_pkg::HS_NONE;
      rx_cnt <= 4'h0;
      tx_idx <= 4'h0;
      o_hs_valid <= 1'b0;
      o_hs_code <= ezc_pkg::HS_ACK;
      o_tx_start <= 1'b0;
      o_tx_data1 <= 1'b0;
      o_tx_valid <= 1'b0;
      o_tx_end <= 1'b0;
    end
    else
    begin
      o_hs_valid <= 1'b0;
      o_tx_start <= 1'b0;
      o_tx_end <= 1'b0;
      case (state)
        ezc_pkg::ST_IDLE:
        begin
          if (tok0 && (i_tok_pid == ezc_pkg::TOK_SETUP))
          begin
            state <= ezc_pkg::ST_SETUP;
          end
          else if (tok0 && (i_tok_pid == ezc_pkg::TOK_OUT))
          begin
            resp <= out_decide;
            state <= ezc_pkg::ST_OUT;
          end
          else if (tok0 && (i_tok_pid == ezc_pkg::TOK_IN))
          begin
            if (in_decide == ezc_pkg::HS_ACK)
            begin
              o_tx_start <= 1'b1;
              o_tx_data1 <= in_cfg[ezc_pkg::CFG_TOGGLE];
              if (in_count == 4'h0)
              begin
                o_tx_end <= 1'b1;
                state <= ezc_pkg::ST_WAIT;
              end
              else
              begin
                o_tx_valid <= 1'b1;
                state <= ezc_pkg::ST_TX;
              end
            end
            else if (in_decide != ezc_pkg::HS_NONE)
            begin
              o_hs_valid <= 1'b1;
              o_hs_code <= in_decide;
            end
          end
        end
        ezc_pkg::ST_SETUP, ezc_pkg::ST_OUT:
        begin
          if (i_rx_valid && (rx_cnt < ezc_pkg::MAX_PKT))
          begin
            rx_cnt <= 4'(rx_cnt + 4'h1);
          end
          if (i_rx_end)
          begin
            state <= ezc_pkg::ST_IDLE;
            rx_cnt <= 4'h0;
            if (ev_setup)
            begin
              o_hs_valid <= 1'b1;
              o_hs_code <= ezc_pkg::HS_ACK;
            end
            else if ((state == ezc_pkg::ST_OUT) && i_rx_ok && (resp != ezc_pkg::HS_NONE))
            begin
              o_hs_valid <= 1'b1;
              o_hs_code <= resp;
            end
          end
        end
        ezc_pkg::ST_TX:
        begin
          if (tx_fire)
          begin
            tx_idx <= 4'(tx_idx + 4'h1);
            if (4'(tx_idx + 4'h1) == in_count)
            begin
              o_tx_valid <= 1'b0;
              o_tx_end <= 1'b1;
              state <= ezc_pkg::ST_WAIT;
            end
          end
        end
        ezc_pkg::ST_WAIT:
        begin
          if (i_hs_ack || i_hs_timeout || i_tok_valid)
          begin
            tx_idx <= 4'h0;
            state <= ezc_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state <= ezc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // configuration bytes: hardware refuse and toggle updates win over a write
  always_comb
  begin
    next_out_cfg = (i_wr && (i_addr == ezc_pkg::REG_OUT0_CFG)) ? i_wdata : out_cfg;
    next_in_cfg = (i_wr && (i_addr == ezc_pkg::REG_IN0_CFG)) ? i_wdata : in_cfg;
    if (ev_out)
    begin
      next_out_cfg[ezc_pkg::CFG_REFUSE] = 1'b1;
      next_out_cfg[ezc_pkg::CFG_TOGGLE] = ~out_cfg[ezc_pkg::CFG_TOGGLE];
    end
    if (ev_in)
    begin
      next_in_cfg[ezc_pkg::CFG_REFUSE] = 1'b1;
      next_in_cfg[ezc_pkg::CFG_TOGGLE] = ~in_cfg[ezc_pkg::CFG_TOGGLE];
    end
  end

  // endpoint zero configuration, sizes, bases and byte counts
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      out_cfg <= ezc_pkg::CFG_RESET;
      in_cfg <= ezc_pkg::CFG_RESET;
      out_base <= 4'h0;
      in_base <= 4'h0;
      out_size <= ezc_pkg::MAX_PKT;
      in_size <= ezc_pkg::MAX_PKT;
      out_count <= 4'h0;
      in_count <= 4'h0;
    end
    else
    begin
      out_cfg <= next_out_cfg;
      in_cfg <= next_in_cfg;
      if (i_wr && (i_addr == ezc_pkg::REG_OUT0_BASE))
        out_base <= i_wdata[3:0];
      if (i_wr && (i_addr == ezc_pkg::REG_IN0_BASE))
        in_base <= i_wdata[3:0];
      if (i_wr && (i_addr == ezc_pkg::REG_OUT0_SIZE))
        out_size <= i_wdata[3:0];
      if (i_wr && (i_addr == ezc_pkg::REG_IN0_SIZE))
        in_size <= i_wdata[3:0];
      if (ev_out)
        out_count <= rx_cnt;
      if (i_wr && (i_addr == ezc_pkg::REG_IN0_COUNT))
        in_count <= (i_wdata[3:0] > in_size) ? in_size : i_wdata[3:0];
    end
  end

  // request-pending flag and sticky event flags, set wins over clear
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      pending <= 1'b0;
      int_flags <= 3'h0;
    end
    else
    begin
      if (ev_setup)
        pending <= 1'b1;
      else if (i_wr && (i_addr == ezc_pkg::REG_STATUS) && i_wdata[ezc_pkg::STATUS_PENDING])
        pending <= 1'b0;
      else if (i_wr && (i_addr == ezc_pkg::REG_INT_FLAGS) && i_wdata[ezc_pkg::INT_SETUP])
        pending <= 1'b0;
      int_flags <= (int_flags & ~((i_wr && (i_addr == ezc_pkg::REG_INT_FLAGS)) ? i_wdata[2:0] : 3'h0))
        | {ev_in, ev_out, ev_setup};
    end
  end

  // interrupt lines, OUT and IN gated by each half's interrupt enable, setup line ungated
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      o_setup_irq <= 1'b0;
      o_ep0_out_irq <= 1'b0;
      o_ep0_in_irq <= 1'b0;
    end
    else
    begin
      o_setup_irq <= int_flags[ezc_pkg::INT_SETUP];
      o_ep0_out_irq <= int_flags[ezc_pkg::INT_OUT0] && out_cfg[ezc_pkg::CFG_INT_EN];
      o_ep0_in_irq <= int_flags[ezc_pkg::INT_IN0] && in_cfg[ezc_pkg::CFG_INT_EN];
    end
  end

  // transfer type of endpoints one to seven in each direction
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      for (int k = 0; k < ezc_pkg::TYPE_REGS; k++)
        ep_type[k] <= 8'h00;
    end
    else if (i_wr && (i_addr >= ezc_pkg::REG_EP_TYPE0))
    begin
      ep_type[i_addr[1:0]] <= i_wdata;
    end
  end

  assign o_in_ep_type = {ep_type[1][5:0], ep_type[0]};
  assign o_out_ep_type = {ep_type[3][5:0], ep_type[2]};

  // buffer window pointer and register read data
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      buf_ptr <= 4'h0;
      o_rdata <= 8'h00;
    end
    else
    begin
      buf_ptr <= next_buf_ptr;
      if (i_rd)
      begin
        case (i_addr)
          ezc_pkg::REG_OUT0_CFG: o_rdata <= out_cfg;
          ezc_pkg::REG_OUT0_BASE: o_rdata <= {4'h0, out_base};
          ezc_pkg::REG_OUT0_SIZE: o_rdata <= {4'h0, out_size};
          ezc_pkg::REG_OUT0_COUNT: o_rdata <= {4'h0, out_count};
          ezc_pkg::REG_IN0_CFG: o_rdata <= in_cfg;
          ezc_pkg::REG_IN0_BASE: o_rdata <= {4'h0, in_base};
          ezc_pkg::REG_IN0_SIZE: o_rdata <= {4'h0, in_size};
          ezc_pkg::REG_IN0_COUNT: o_rdata <= {4'h0, in_count};
          ezc_pkg::REG_STATUS: o_rdata <= {7'h00, pending};
          ezc_pkg::REG_INT_FLAGS: o_rdata <= {5'h00, int_flags};
          ezc_pkg::REG_BUF_PTR: o_rdata <= {4'h0, buf_ptr};
          ezc_pkg::REG_BUF_DATA: o_rdata <= out_rdata;
          default: o_rdata <= ep_type[i_addr[1:0]];
        endcase
      end
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  a_setup_ack: assert property (ev_setup |=> o_hs_valid && o_hs_code == ezc_pkg::HS_ACK && pending)
    else $error("setup packet not acknowledged");
  a_pending_nak: assert property (tok0 && i_tok_pid == ezc_pkg::TOK_IN && pending
    && in_cfg[ezc_pkg::CFG_ENABLE] |=> o_hs_valid && o_hs_code == ezc_pkg::HS_NAK && !o_tx_start)
    else $error("pending request did not force NAK");
  a_setup_clear: assert property (i_wr && i_addr == ezc_pkg::REG_INT_FLAGS
    && i_wdata[ezc_pkg::INT_SETUP] && !ev_setup |=> !pending)
    else $error("setup flag clear left request pending");
  a_halt_stall: assert property (tok0 && i_tok_pid == ezc_pkg::TOK_IN && !pending
    && in_cfg[ezc_pkg::CFG_ENABLE] && in_cfg[ezc_pkg::CFG_HALT]
    |=> o_hs_valid && o_hs_code == ezc_pkg::HS_STALL)
    else $error("halted endpoint did not stall");
  a_refuse_nak: assert property (tok0 && i_tok_pid == ezc_pkg::TOK_IN && in_decide == ezc_pkg::HS_NAK
    |=> o_hs_code == ezc_pkg::HS_NAK ##1 state == ezc_pkg::ST_IDLE)
    else $error("refused endpoint did not NAK");
  a_out_update: assert property (ev_out |=> out_cfg[ezc_pkg::CFG_REFUSE] && o_hs_valid
    && out_cfg[ezc_pkg::CFG_TOGGLE] != $past(out_cfg[ezc_pkg::CFG_TOGGLE]))
    else $error("OUT packet did not update endpoint");
  a_err_silent: assert property (state == ezc_pkg::ST_OUT && i_rx_end && !i_rx_ok |=> !o_hs_valid)
    else $error("handshake sent for bad packet");
  a_in_ack: assert property (ev_in |=> in_cfg[ezc_pkg::CFG_REFUSE] && int_flags[ezc_pkg::INT_IN0])
    else $error("IN acknowledge did not update endpoint");
  a_in_retry: assert property (state == ezc_pkg::ST_WAIT && i_hs_timeout && !i_hs_ack
    && !(i_wr && i_addr == ezc_pkg::REG_IN0_CFG) |=> in_cfg == $past(in_cfg) && tx_idx == 4'h0)
    else $error("missing handshake changed IN state");
  a_other_ep: assert property (i_tok_valid && i_tok_ep != ezc_pkg::EP0 |=> !o_hs_valid && !o_tx_start)
    else $error("non-zero endpoint answered");
  c_setup: cover property (ev_setup);
  c_out_data: cover property (ev_out);
  c_in_ack: cover property (ev_in);
  c_retry: cover property (state == ezc_pkg::ST_WAIT && i_hs_timeout);
endmodule

// file: ezc_host_model.sv
// host and serial engine model facing the endpoint zero control block
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/1ps
module ezc_host_model
(
  input wire logic i_clock,
  input wire logic i_tx_start,
  input wire logic i_tx_data1,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_end,
  input wire logic i_hs_valid,
  input wire logic [1:0] i_hs_code,
  output logic o_tok_valid = 1'b0,
  output logic [1:0] o_tok_pid = 2'h0,
  output logic [3:0] o_tok_ep = 4'h0,
  output logic o_rx_valid = 1'b0,
  output logic [7:0] o_rx_data = 8'h00,
  output logic o_rx_end = 1'b0,
  output logic o_rx_ok = 1'b0,
  output logic o_rx_data1 = 1'b0,
  output logic o_tx_ready = 1'b1,
  output logic o_hs_ack = 1'b0,
  output logic o_hs_timeout = 1'b0
);
  int hs_cnt = 0;
  logic [1:0] hs_last = 2'h3;
  // record every handshake the device returns
  always @(posedge i_clock)
    if (i_hs_valid === 1'b1)
    begin
      hs_cnt <= hs_cnt + 1;
      hs_last <= i_hs_code;
    end
  // one token cycle; fields are scrambled once it is gone
  task automatic token(input logic [1:0] pid, input logic [3:0] ep);
    @(posedge i_clock);
    o_tok_valid <= 1'b1;
    o_tok_pid <= pid;
    o_tok_ep <= ep;
    @(posedge i_clock);
    o_tok_valid <= 1'b0;
    o_tok_pid <= ~pid;
    o_tok_ep <= ~ep;
  endtask
  // token, n bytes 30h upward back to back, then end with error and pid flags
  task automatic out_pkt(input logic [1:0] pid, input logic [3:0] ep, input int n,
                         input logic ok, input logic d1);
    token(pid, ep);
    for (int i = 0; i < n; i++)
    begin
      @(posedge i_clock);
      o_rx_valid <= 1'b1;
      o_rx_data <= 8'h30 + 8'(i);
    end
    @(posedge i_clock);
    o_rx_valid <= 1'b0;
    o_rx_data <= ~o_rx_data;
    o_rx_end <= 1'b1;
    o_rx_ok <= ok;
    o_rx_data1 <= d1;
    @(posedge i_clock);
    o_rx_end <= 1'b0;
    o_rx_ok <= ~ok;
    o_rx_data1 <= ~d1;
  endtask
  // IN token, take the packet while stalling every other cycle, then ack or stay silent
  task automatic in_pkt(input logic ack, output int n, output logic [7:0] b0,
                        output logic [7:0] b1, output logic d1);
    int k;
    n = 0;
    d1 = 1'bx;
    b0 = 8'hxx;
    b1 = 8'hxx;
    token(2'h2, 4'h0);
    for (k = 0; k < 40; k++)
    begin
      @(posedge i_clock);
      if (i_tx_start === 1'b1)
        d1 = i_tx_data1;
      if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1)
      begin
        if (n == 0)
          b0 = i_tx_data;
        else
          b1 = i_tx_data;
        n++;
      end
      if (i_tx_end === 1'b1)
        break;
      o_tx_ready <= ~o_tx_ready;
    end
    // no end of packet within the bound: report it through the count
    if (k == 40)
      n = -1;
    @(posedge i_clock);
    o_hs_ack <= ack; // host acknowledges only when the ack argument is set
    o_hs_timeout <= ~ack;
    @(posedge i_clock);
    o_hs_ack <= 1'b0;
    o_hs_timeout <= 1'b0;
  endtask
endmodule

// file: tb_usb_endpoint_zero_control.sv
// self-checking bench for the endpoint zero control block
// assumes the host model drives the engine side and this bench the mcu side
`timescale 1ns/1ps
module tb_usb_endpoint_zero_control;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata, tx_data, b0, b1, v;
  logic tok_valid, rx_valid, rx_end, rx_ok, rx_data1, tx_ready, hs_ack, hs_to;
  logic hs_valid, tx_start, tx_data1, tx_valid, tx_end, d1;
  logic setup_irq, out_irq, in_irq;
  logic [1:0] tok_pid, hs_code;
  logic [3:0] tok_ep;
  logic [7:0] rx_data;
  logic [13:0] in_types, out_types;
  int errors = 0;
  int cmp_count = 0;
  int n;
  ezc_ep0_ctrl dut_u (.i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tok_valid(tok_valid),
    .i_tok_pid(tok_pid), .i_tok_ep(tok_ep), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .i_rx_end(rx_end), .i_rx_ok(rx_ok), .i_rx_data1(rx_data1), .i_tx_ready(tx_ready),
    .i_hs_ack(hs_ack), .i_hs_timeout(hs_to), .o_hs_valid(hs_valid), .o_hs_code(hs_code),
    .o_tx_start(tx_start), .o_tx_data1(tx_data1), .o_tx_valid(tx_valid),
    .o_tx_data(tx_data), .o_tx_end(tx_end), .o_setup_irq(setup_irq),
    .o_ep0_out_irq(out_irq), .o_ep0_in_irq(in_irq), .o_in_ep_type(in_types),
    .o_out_ep_type(out_types));
  ezc_host_model host_u (.i_clock(i_clock), .i_tx_start(tx_start), .i_tx_data1(tx_data1),
    .i_tx_valid(tx_valid), .i_tx_data(tx_data), .i_tx_end(tx_end), .i_hs_valid(hs_valid),
    .i_hs_code(hs_code), .o_tok_valid(tok_valid), .o_tok_pid(tok_pid), .o_tok_ep(tok_ep),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_end(rx_end), .o_rx_ok(rx_ok),
    .o_rx_data1(rx_data1), .o_tx_ready(tx_ready), .o_hs_ack(hs_ack), .o_hs_timeout(hs_to));
  // 25 MHz clock
  initial
  begin
    forever #20 i_clock = ~i_clock;
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // a bounded wait ran out: count it and close the run
  task automatic give_up();
    errors++;
    $display("FAIL t=%0t wait ran out", $time);
    report_and_stop();
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  // read data stand from the cycle after the strobe until the next read
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // wait a bounded time for a handshake; code 3 means none is allowed
  task automatic expect_hs(input int n0, input logic [1:0] code);
    int k;
    for (k = 0; k < 10 && host_u.hs_cnt == n0; k++)
      @(posedge i_clock);
    if (code == 2'h3)
      chk(8'(host_u.hs_cnt - n0), 8'h00);
    else if (k == 10)
      give_up();
    else
      chk({6'h00, host_u.hs_last}, {6'h00, code});
  endtask
  task automatic t_setup();
    wr(ezc_pkg::REG_OUT0_CFG, 8'ha8); // enabled, halted and refusing
    host_u.out_pkt(ezc_pkg::TOK_SETUP, 4'h0, 8, 1'b1, 1'b0);
    expect_hs(0, ezc_pkg::HS_ACK);
    rd(ezc_pkg::REG_STATUS, v);
    chk(v & 8'h01, 8'h01);
    chk({7'h00, setup_irq}, 8'h01);
    wr(ezc_pkg::REG_BUF_PTR, {4'h0, ezc_pkg::SETUP_BASE});
    rd(ezc_pkg::REG_BUF_DATA, v);
    chk(v, 8'h30);
    rd(ezc_pkg::REG_BUF_DATA, v);
    chk(v, 8'h31);
    $display("setup stage done");
  endtask
  task automatic t_pending_halt();
    wr(ezc_pkg::REG_IN0_CFG, 8'ha0);
    host_u.out_pkt(ezc_pkg::TOK_OUT, 4'h0, 1, 1'b1, 1'b1);
    expect_hs(1, ezc_pkg::HS_NAK);
    host_u.token(ezc_pkg::TOK_IN, 4'h0);
    expect_hs(2, ezc_pkg::HS_NAK);
    wr(ezc_pkg::REG_INT_FLAGS, 8'h01);
    rd(ezc_pkg::REG_STATUS, v);
    chk(v & 8'h01, 8'h00);
    host_u.out_pkt(ezc_pkg::TOK_OUT, 4'h0, 1, 1'b1, 1'b1);
    expect_hs(3, ezc_pkg::HS_STALL);
    host_u.token(ezc_pkg::TOK_IN, 4'h0);
    expect_hs(4, ezc_pkg::HS_STALL);
    $display("pending and halt done");
  endtask
  task automatic t_out();
    wr(ezc_pkg::REG_OUT0_BASE, 8'h00);
    wr(ezc_pkg::REG_OUT0_CFG, 8'hd0);
    host_u.out_pkt(ezc_pkg::TOK_OUT, 4'h1, 2, 1'b1, 1'b1);
    expect_hs(5, 2'h3);
    host_u.out_pkt(ezc_pkg::TOK_OUT, 4'h0, 3, 1'b1, 1'b1);
    expect_hs(5, ezc_pkg::HS_ACK);
    rd(ezc_pkg::REG_OUT0_COUNT, v);
    chk(v, 8'h03);
    rd(ezc_pkg::REG_OUT0_CFG, v);
    chk(v, 8'hc8);
    chk({7'h00, out_irq}, 8'h01);
    wr(ezc_pkg::REG_BUF_PTR, 8'h02);
    rd(ezc_pkg::REG_BUF_DATA, v);
    chk(v, 8'h32);
    host_u.out_pkt(ezc_pkg::TOK_OUT, 4'h0, 2, 1'b1, 1'b0);
    expect_hs(6, ezc_pkg::HS_NAK);
    rd(ezc_pkg::REG_OUT0_COUNT, v);
    chk(v, 8'h03);
    wr(ezc_pkg::REG_INT_FLAGS, 8'h02);
    wr(ezc_pkg::REG_OUT0_CFG, 8'hc0);
    host_u.out_pkt(ezc_pkg::TOK_OUT, 4'h0, 2, 1'b0, 1'b0);
    expect_hs(7, 2'h3);
    rd(ezc_pkg::REG_OUT0_CFG, v);
    chk(v, 8'hc0);
    // status stage of a control read: zero-length DATA1 packet
    wr(ezc_pkg::REG_OUT0_CFG, 8'hd0);
    host_u.out_pkt(ezc_pkg::TOK_OUT, 4'h0, 0, 1'b1, 1'b1);
    expect_hs(7, ezc_pkg::HS_ACK);
    rd(ezc_pkg::REG_OUT0_COUNT, v);
    chk(v, 8'h00);
    rd(ezc_pkg::REG_OUT0_CFG, v);
    chk(v, 8'hc8);
    $display("out data stage done");
  endtask
  task automatic t_in();
    wr(ezc_pkg::REG_IN0_BASE, 8'h00);
    wr(ezc_pkg::REG_BUF_PTR, 8'h00);
    wr(ezc_pkg::REG_BUF_DATA, 8'h5a);
    wr(ezc_pkg::REG_BUF_DATA, 8'ha5);
    wr(ezc_pkg::REG_IN0_COUNT, 8'h02);
    wr(ezc_pkg::REG_IN0_CFG, 8'hd0);
    for (int r = 0; r < 2; r++)
    begin
      host_u.in_pkt(r[0], n, b0, b1, d1);
      if (n < 0)
        give_up();
      chk(8'(n), 8'h02);
      chk(b0, 8'h5a);
      chk(b1, 8'ha5);
      chk({7'h00, d1}, 8'h01);
      repeat (2) @(posedge i_clock);
      rd(ezc_pkg::REG_IN0_CFG, v);
      chk(v, r == 0 ? 8'hd0 : 8'hc8);
    end
    chk({7'h00, in_irq}, 8'h01);
    host_u.token(ezc_pkg::TOK_IN, 4'h0);
    expect_hs(8, ezc_pkg::HS_NAK);
    wr(ezc_pkg::REG_INT_FLAGS, 8'h04);
    wr(ezc_pkg::REG_IN0_COUNT, 8'h00);
    wr(ezc_pkg::REG_IN0_CFG, 8'hd0);
    host_u.in_pkt(1'b1, n, b0, b1, d1);
    if (n < 0)
      give_up();
    chk(8'(n), 8'h00);
    chk({7'h00, d1}, 8'h01);
    $display("in stages done");
  endtask
  // transfer type registers of the other endpoints and their outputs
  task automatic t_types();
    wr(ezc_pkg::REG_EP_TYPE0, 8'h1b);
    wr(4'hd, 8'h27);
    wr(4'he, 8'he4);
    wr(4'hf, 8'h39);
    rd(4'hf, v);
    chk(v, 8'h39);
    chk(in_types[7:0], 8'h1b);
    chk({2'h0, in_types[13:8]}, 8'h27);
    chk(out_types[7:0], 8'he4);
    chk({2'h0, out_types[13:8]}, 8'h39);
    $display("endpoint types done");
  endtask
  // main sequence
  initial
  begin
    repeat (12) @(posedge i_clock);
    i_reset <= 1'b0;
    rd(ezc_pkg::REG_OUT0_SIZE, v);
    chk(v, 8'h08);
    rd(ezc_pkg::REG_OUT0_CFG, v);
    chk(v, ezc_pkg::CFG_RESET);
    t_setup();
    t_pending_halt();
    t_out();
    t_in();
    t_types();
    report_and_stop();
  end
  // cut a hung run short
  initial
  begin
    #2000000;
    give_up();
  end
endmodule
